// ### design/strap_defs.svh
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH

// Comparator pair layout: bit 1 above the high threshold, bit 0 below the low one
`define CMP_HI_BIT        1
`define CMP_LO_BIT        0
`define CMP_CODE_HIGH     2'b10
`define CMP_CODE_LOW      2'b01
`define CMP_CODE_MID      2'b00
`define CMP_CODE_BAD      2'b11

// Reset values of the synchroniser stages and pin levels
`define CMP_RST           2'b00
`define PIN_RST           1'b0

// Power-up calibration delay, in input clock cycles
`define CAL_CNT_W         24
`define CAL_DLY_SHORT_DEF 24'h00_0400
`define CAL_DLY_LONG_DEF  24'h01_0000
`define CAL_CNT_RST       24'h00_0000
`define CAL_CNT_ONE       24'h00_0001

`endif

// ### design/strap_pkg.sv
`include "strap_defs.svh"
`default_nettype none

package strap_pkg;

   typedef enum logic [1:0] {
      LVL_LOW,
      LVL_HIGH,
      LVL_MID
   } level_e;

   typedef enum logic [1:0] {
      CAL_WAIT,
      CAL_DONE
   } cal_state_e;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      level_e     lvl;
      logic       chg;
   } tri_sync_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rise;
      logic fall;
   } edge_sync_s;

   // Maps a settled comparator pair to a pin level; the illegal code is never passed in
   function automatic level_e cmp_to_level(input logic [1:0] code);
      level_e lvl;
      lvl = LVL_MID;
      if (code == `CMP_CODE_HIGH) begin
         lvl = LVL_HIGH;
      end else if (code == `CMP_CODE_LOW) begin
         lvl = LVL_LOW;
      end
      return lvl;
   endfunction

endpackage

`default_nettype wire

// ### design/tri_level_sync.sv
`include "strap_defs.svh"
`default_nettype none

module tri_level_sync
   import strap_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   // Threshold comparators of the pin
   input  wire logic       cmp_hi_in,
   input  wire logic       cmp_lo_in,
   // Settled level
   output level_e          level_out,
   output logic            changed_out
);

   localparam tri_sync_s RST_ST = '{s1: `CMP_RST, s2: `CMP_RST, s3: `CMP_RST,
                                    lvl: LVL_MID, chg: 1'b0};

   tri_sync_s st_ff;
   tri_sync_s nxt_st;

   always_comb begin
      nxt_st     = st_ff;
      nxt_st.s1  = {cmp_hi_in, cmp_lo_in};
      nxt_st.s2  = st_ff.s1;
      nxt_st.s3  = st_ff.s2;
      nxt_st.chg = 1'b0;
      // Both thresholds at once is a glitch mid-transition; hold the old level
      if ((st_ff.s2 == st_ff.s3) && (st_ff.s3 != `CMP_CODE_BAD)) begin
         nxt_st.lvl = cmp_to_level(st_ff.s3);
         nxt_st.chg = (cmp_to_level(st_ff.s3) != st_ff.lvl);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         st_ff <= RST_ST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_out   = st_ff.lvl;
   assign changed_out = st_ff.chg;

endmodule // tri_level_sync

`default_nettype wire

// ### design/pin_edge_sync.sv
`include "strap_defs.svh"
`default_nettype none

module pin_edge_sync
   import strap_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   // Asynchronous pin
   input  wire logic       pin_in,
   // Settled level and edge pulses
   output logic            level_out,
   output logic            rise_out,
   output logic            fall_out
);

   localparam edge_sync_s RST_ST = '{s1: `PIN_RST, s2: `PIN_RST, s3: `PIN_RST,
                                     lvl: `PIN_RST, rise: 1'b0, fall: 1'b0};

   edge_sync_s st_ff;
   edge_sync_s nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.s1   = pin_in;
      nxt_st.s2   = st_ff.s1;
      nxt_st.s3   = st_ff.s2;
      nxt_st.rise = 1'b0;
      nxt_st.fall = 1'b0;
      if (st_ff.s2 == st_ff.s3) begin
         nxt_st.lvl  = st_ff.s3;
         nxt_st.rise = st_ff.s3 & ~st_ff.lvl;
         nxt_st.fall = ~st_ff.s3 & st_ff.lvl;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         st_ff <= RST_ST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_out = st_ff.lvl;
   assign rise_out  = st_ff.rise;
   assign fall_out  = st_ff.fall;

endmodule // pin_edge_sync

`default_nettype wire

// ### design/strap_pin_mode_decoder.sv
`include "strap_defs.svh"
`default_nettype none

module strap_pin_mode_decoder
   import strap_pkg::*;
#(
   parameter logic [`CAL_CNT_W-1:0] CAL_DLY_SHORT_CLKS = `CAL_DLY_SHORT_DEF,
   parameter logic [`CAL_CNT_W-1:0] CAL_DLY_LONG_CLKS  = `CAL_DLY_LONG_DEF
)
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,

   // Range / alternate enable / negative reset leg pin comparators
   input  wire logic       range_cmp_hi_in,
   input  wire logic       range_cmp_lo_in,

   // Reset type select pin comparators
   input  wire logic       reset_sel_cmp_hi_in,
   input  wire logic       reset_sel_cmp_lo_in,

   // Dedicated extended control enable pin comparators
   input  wire logic       ext_en_cmp_hi_in,
   input  wire logic       ext_en_cmp_lo_in,

   // Calibration delay / dual edge / chip select pin comparators
   input  wire logic       cal_cmp_hi_in,
   input  wire logic       cal_cmp_lo_in,

   // Digital pins
   input  wire logic       sample_clk_pos_in,
   input  wire logic       out_clk_reset_pos_in,

   // Control mode
   output logic            ext_ctrl_mode_out,
   output logic            alt_ext_ctrl_enable_out,
   output logic            range_select_high_out,

   // Output clock reset
   output logic            diff_reset_mode_out,
   output logic            out_clk_reset_neg_out,
   output logic            out_clk_reset_out,

   // Calibration delay and sampling
   output logic            cal_delay_long_out,
   output logic            cal_start_out,
   output logic            cal_pending_out,
   output logic            dual_edge_mode_out,
   output logic            i_sample_strobe_out,
   output logic            q_sample_strobe_out,

   // Serial interface and status
   output logic            serial_chip_select_out,
   output logic            mode_change_out
);

   typedef struct packed {
      logic                  ext_mode;
      logic                  alt_en;
      logic                  range_high;
      logic                  diff_reset;
      logic                  reset_neg;
      logic                  reset_pulse;
      logic                  cal_long;
      logic                  cal_start;
      cal_state_e            cal_state;
      logic                  cal_pend;
      logic [`CAL_CNT_W-1:0] cal_cnt;
      logic                  dual_edge;
      logic                  i_strobe;
      logic                  q_strobe;
      logic                  serial_cs;
      logic                  mode_chg;
   } decode_s;

   // Reset shows pin control, higher range, chip select idle, calibration waiting
   localparam decode_s RST_ST = '{
      ext_mode:    1'b0,
      alt_en:      1'b0,
      range_high:  1'b1,
      diff_reset:  1'b0,
      reset_neg:   1'b0,
      reset_pulse: 1'b0,
      cal_long:    1'b0,
      cal_start:   1'b0,
      cal_state:   CAL_WAIT,
      cal_pend:    1'b1,
      cal_cnt:     `CAL_CNT_RST,
      dual_edge:   1'b0,
      i_strobe:    1'b0,
      q_strobe:    1'b0,
      serial_cs:   1'b1,
      mode_chg:    1'b0
   };

   decode_s st_ff;
   decode_s nxt_st;

   level_e  range_lvl;
   level_e  reset_sel_lvl;
   level_e  ext_en_lvl;
   level_e  cal_lvl;
   logic    range_chg;
   logic    reset_sel_chg;
   logic    ext_en_chg;
   logic    cal_chg;
   logic    clk_pos_rise;
   logic    clk_pos_fall;
   logic    reset_pos_lvl;

   // Three-level strap inputs
   tri_level_sync u_range_sync (
      .sys_clk_in  (sys_clk_in),
      .srst_in     (srst_in),
      .cmp_hi_in   (range_cmp_hi_in),
      .cmp_lo_in   (range_cmp_lo_in),
      .level_out   (range_lvl),
      .changed_out (range_chg)
   );

   tri_level_sync u_reset_sel_sync (
      .sys_clk_in  (sys_clk_in),
      .srst_in     (srst_in),
      .cmp_hi_in   (reset_sel_cmp_hi_in),
      .cmp_lo_in   (reset_sel_cmp_lo_in),
      .level_out   (reset_sel_lvl),
      .changed_out (reset_sel_chg)
   );

   tri_level_sync u_ext_en_sync (
      .sys_clk_in  (sys_clk_in),
      .srst_in     (srst_in),
      .cmp_hi_in   (ext_en_cmp_hi_in),
      .cmp_lo_in   (ext_en_cmp_lo_in),
      .level_out   (ext_en_lvl),
      .changed_out (ext_en_chg)
   );

   tri_level_sync u_cal_sync (
      .sys_clk_in  (sys_clk_in),
      .srst_in     (srst_in),
      .cmp_hi_in   (cal_cmp_hi_in),
      .cmp_lo_in   (cal_cmp_lo_in),
      .level_out   (cal_lvl),
      .changed_out (cal_chg)
   );

   // Two-level digital pins
   pin_edge_sync u_clk_pos_sync (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .pin_in     (sample_clk_pos_in),
      .level_out  (),
      .rise_out   (clk_pos_rise),
      .fall_out   (clk_pos_fall)
   );

   pin_edge_sync u_reset_pos_sync (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .pin_in     (out_clk_reset_pos_in),
      .level_out  (reset_pos_lvl),
      .rise_out   (),
      .fall_out   ()
   );

   always_comb begin
      logic                  range_pin_free;
      logic                  alt_en;
      logic                  ext_mode;
      logic                  diff_reset;
      logic                  neg_high;
      logic                  cal_long;
      logic [`CAL_CNT_W-1:0] cal_target;

      range_pin_free = 1'b0;
      alt_en         = 1'b0;
      ext_mode       = 1'b0;
      diff_reset     = 1'b0;
      neg_high       = 1'b0;
      cal_long       = 1'b0;
      cal_target     = CAL_DLY_SHORT_CLKS;
      nxt_st         = st_ff;

      diff_reset     = (reset_sel_lvl == LVL_LOW);
      range_pin_free = !diff_reset && (ext_en_lvl == LVL_MID);
      alt_en         = range_pin_free && (range_lvl == LVL_MID);

      // Dedicated pin decides whenever it is driven
      unique case (ext_en_lvl)
         LVL_LOW:  ext_mode = 1'b1;
         LVL_HIGH: ext_mode = 1'b0;
         LVL_MID:  ext_mode = alt_en;
      endcase

      nxt_st.ext_mode   = ext_mode;
      nxt_st.alt_en     = alt_en;
      nxt_st.diff_reset = diff_reset;
      // Only an eligible low reduces the range; every other case keeps the higher one
      nxt_st.range_high = !(range_pin_free && (range_lvl == LVL_LOW));

      // Negative leg only means something in differential reset mode
      neg_high           = diff_reset && (range_lvl == LVL_HIGH);
      nxt_st.reset_neg   = neg_high;
      if (diff_reset) begin
         nxt_st.reset_pulse = reset_pos_lvl && (range_lvl == LVL_LOW);
      end else begin
         nxt_st.reset_pulse = reset_pos_lvl;
      end

      // Calibration pin function follows the control mode
      if (ext_mode) begin
         cal_long         = 1'b0;
         nxt_st.dual_edge = 1'b0;
         nxt_st.serial_cs = (cal_lvl == LVL_HIGH);
      end else begin
         cal_long         = (cal_lvl == LVL_HIGH);
         nxt_st.dual_edge = (cal_lvl == LVL_MID);
         nxt_st.serial_cs = 1'b1;
      end
      nxt_st.cal_long = cal_long;

      // Dual-edge mode takes I on both clock edges and drops Q
      nxt_st.i_strobe = clk_pos_fall || (st_ff.dual_edge && clk_pos_rise);
      nxt_st.q_strobe = clk_pos_fall && !st_ff.dual_edge;

      // Power-up delay counts input clock cycles; a strap change mid-count retargets it
      cal_target       = cal_long ? CAL_DLY_LONG_CLKS : CAL_DLY_SHORT_CLKS;
      nxt_st.cal_start = 1'b0;
      unique case (st_ff.cal_state)
         CAL_WAIT: begin
            if (clk_pos_fall) begin
               if (st_ff.cal_cnt + `CAL_CNT_ONE >= cal_target) begin
                  nxt_st.cal_start = 1'b1;
                  nxt_st.cal_state = CAL_DONE;
                  nxt_st.cal_pend  = 1'b0;
               end else begin
                  nxt_st.cal_cnt = st_ff.cal_cnt + `CAL_CNT_ONE;
               end
            end
         end
         CAL_DONE: begin
            nxt_st.cal_cnt = st_ff.cal_cnt;
         end
         default: begin
            nxt_st.cal_state = CAL_WAIT;
         end
      endcase

      // Decode also moves just after reset, with no strap change behind it
      nxt_st.mode_chg = range_chg || reset_sel_chg || ext_en_chg || cal_chg
                        || (nxt_st.ext_mode != st_ff.ext_mode)
                        || (nxt_st.alt_en != st_ff.alt_en)
                        || (nxt_st.diff_reset != st_ff.diff_reset)
                        || (nxt_st.dual_edge != st_ff.dual_edge)
                        || (nxt_st.range_high != st_ff.range_high);
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         st_ff <= RST_ST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ext_ctrl_mode_out       = st_ff.ext_mode;
   assign alt_ext_ctrl_enable_out = st_ff.alt_en;
   assign range_select_high_out   = st_ff.range_high;
   assign diff_reset_mode_out     = st_ff.diff_reset;
   assign out_clk_reset_neg_out   = st_ff.reset_neg;
   assign out_clk_reset_out       = st_ff.reset_pulse;
   assign cal_delay_long_out      = st_ff.cal_long;
   assign cal_start_out           = st_ff.cal_start;
   assign cal_pending_out         = st_ff.cal_pend;
   assign dual_edge_mode_out      = st_ff.dual_edge;
   assign i_sample_strobe_out     = st_ff.i_strobe;
   assign q_sample_strobe_out     = st_ff.q_strobe;
   assign serial_chip_select_out  = st_ff.serial_cs;
   assign mode_change_out         = st_ff.mode_chg;

endmodule // strap_pin_mode_decoder

`default_nettype wire

// ### testbench/strap_mode_props.sv
`default_nettype none

module strap_mode_props (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic srst_in,
   // Watched inputs
   input  wire logic ext_en_cmp_hi_in,
   input  wire logic ext_en_cmp_lo_in,
   input  wire logic sample_clk_pos_in,
   // Watched outputs
   input  wire logic ext_ctrl_mode_out,
   input  wire logic alt_ext_ctrl_enable_out,
   input  wire logic range_select_high_out,
   input  wire logic diff_reset_mode_out,
   input  wire logic cal_delay_long_out,
   input  wire logic cal_start_out,
   input  wire logic cal_pending_out,
   input  wire logic dual_edge_mode_out,
   input  wire logic i_sample_strobe_out,
   input  wire logic q_sample_strobe_out,
   input  wire logic serial_chip_select_out,
   input  wire logic mode_change_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   // Seven samples: the attempt at the release edge is live while the design still resets
   sequence ext_pin_high; (ext_en_cmp_hi_in && !ext_en_cmp_lo_in)[*7]; endsequence
   sequence ext_pin_low;  (!ext_en_cmp_hi_in && ext_en_cmp_lo_in)[*7]; endsequence
   sequence settled_fall; sample_clk_pos_in[*5] ##1 !sample_clk_pos_in[*5]; endsequence

   AST_EXT_PIN_OFF: assert property (ext_pin_high |-> !ext_ctrl_mode_out)
      else $error("ext mode active with control pin high");
   AST_EXT_PIN_ON: assert property (ext_pin_low |-> ext_ctrl_mode_out)
      else $error("ext mode inactive with control pin low");
   AST_DIFF_RANGE: assert property (diff_reset_mode_out |->
      range_select_high_out && !alt_ext_ctrl_enable_out)
      else $error("range pin still controls range in diff reset mode");
   AST_EXT_CAL: assert property (ext_ctrl_mode_out |->
      !cal_delay_long_out && !dual_edge_mode_out)
      else $error("cal pin decoded as delay in ext mode");
   AST_CS_IDLE: assert property (!ext_ctrl_mode_out |-> serial_chip_select_out)
      else $error("chip select active outside ext mode");
   AST_FALL_STROBE: assert property (settled_fall |=>
      i_sample_strobe_out && (q_sample_strobe_out == !dual_edge_mode_out))
      else $error("no sample strobe after clock fall");
   AST_CAL_ONCE: assert property (cal_start_out |=> !cal_start_out && !cal_pending_out)
      else $error("cal start repeated or still pending");
   AST_MODE_CHG: assert property ($changed(ext_ctrl_mode_out) || $changed(dual_edge_mode_out)
      || $changed(range_select_high_out) |-> mode_change_out)
      else $error("mode changed without change pulse");
endmodule // strap_mode_props

`default_nettype wire

// ### testbench/strap_board_model.sv
`default_nettype none

module strap_board_model #(
   parameter int HALF = 6
) (
   input  wire logic       sys_clk_in,
   // Levels: [1:0] range, [3:2] reset select, [5:4] ext enable, [7:6] cal; 0 low 1 high 2 mid
   input  wire logic [7:0] lvl_in,
   input  wire logic       clk_run_in,
   output logic      [3:0] cmp_hi_out,
   output logic      [3:0] cmp_lo_out,
   output logic            clk_pos_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;

   // Floating pin sits between thresholds: neither comparator fires
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         cmp_hi_out[k] = (lvl_in[2*k +: 2] == 2'h1);
         cmp_lo_out[k] = (lvl_in[2*k +: 2] == 2'h0);
      end
   end

   // Clock leg rests low between bursts
   initial clk_pos_out = 1'b0;
   always @(posedge sys_clk_in) begin
      if (!clk_run_in) begin
         cnt <= 0;
         clk_pos_out <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         clk_pos_out <= ~clk_pos_out;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // strap_board_model

`default_nettype wire

// ### testbench/strap_pin_mode_decoder_tb.sv
`default_nettype none

module strap_pin_mode_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SHORT = 4;
   localparam int LONG = 8;
   logic       sys_clk_in = 1'b0;
   logic       srst_in = 1'b1;
   logic       clk_run = 1'b0;
   logic       rst_pos = 1'b0;
   logic [7:0] lvl = 8'h55;
   logic [3:0] hi, lo;
   logic       clk_pos;
   logic       ext, alt, rhigh, diff, neg, rst, cal_long, cal_start, pending, dual;
   logic       i_stb, q_stb, cs, chg;
   logic       fresh = 1'b1;
   int         num_errors = 0, total_checks = 0, n_i = 0, n_q = 0, base_i, base_q;
   int         n_c = 0, base_c;

   always #5 sys_clk_in = ~sys_clk_in;

   always @(posedge sys_clk_in) begin
      n_i <= n_i + int'(i_stb === 1'b1);
      n_q <= n_q + int'(q_stb === 1'b1);
      n_c <= n_c + int'(chg === 1'b1);
   end

   strap_board_model strap_board_model_i (.sys_clk_in(sys_clk_in), .lvl_in(lvl),
      .clk_run_in(clk_run), .cmp_hi_out(hi), .cmp_lo_out(lo), .clk_pos_out(clk_pos));

   strap_pin_mode_decoder #(.CAL_DLY_SHORT_CLKS(SHORT), .CAL_DLY_LONG_CLKS(LONG))
   strap_pin_mode_decoder_i (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .range_cmp_hi_in(hi[0]), .range_cmp_lo_in(lo[0]),
      .reset_sel_cmp_hi_in(hi[1]), .reset_sel_cmp_lo_in(lo[1]),
      .ext_en_cmp_hi_in(hi[2]), .ext_en_cmp_lo_in(lo[2]),
      .cal_cmp_hi_in(hi[3]), .cal_cmp_lo_in(lo[3]),
      .sample_clk_pos_in(clk_pos), .out_clk_reset_pos_in(rst_pos),
      .ext_ctrl_mode_out(ext), .alt_ext_ctrl_enable_out(alt), .range_select_high_out(rhigh),
      .diff_reset_mode_out(diff), .out_clk_reset_neg_out(neg), .out_clk_reset_out(rst),
      .cal_delay_long_out(cal_long), .cal_start_out(cal_start), .cal_pending_out(pending),
      .dual_edge_mode_out(dual), .i_sample_strobe_out(i_stb), .q_sample_strobe_out(q_stb),
      .serial_chip_select_out(cs), .mode_change_out(chg));

   function automatic logic [8:0] model(int r, int s, int e, int c, logic p);
      logic d, f, a, x;
      d = (s == 0);
      f = !d && (e == 2);
      a = f && (r == 2);
      x = (e == 0) ? 1'b1 : (e == 1) ? 1'b0 : a;
      return {x, a, !(f && r == 0), d, d && r == 1, d ? (p && r == 0) : p,
              !x && c == 1, !x && c == 2, x ? (c == 1) : 1'b1};
   endfunction

   task automatic close_out();
      if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check_bits(string name, logic [8:0] exp, logic [8:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_cnt(string name, int exp, int got);
      total_checks++;
      if (got != exp) begin
         num_errors++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   task automatic do_reset();
      @(posedge sys_clk_in) srst_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      check_bits("reset_outputs", 9'h041, {ext, alt, rhigh, diff, neg, rst, cal_long, dual, cs});
      check_bits("reset_pending", 9'h001, {4'h0, cal_start, i_stb, q_stb, chg, pending});
      @(posedge sys_clk_in) srst_in <= 1'b0;
      fresh = 1'b1;
   endtask

   // After reset the synced levels sit at mid, so the first change pulse is always due
   task automatic apply(int k, logic p);
      logic [7:0] l;
      int         e;
      l = {2'(k / 27), 2'(k / 9 % 3), 2'(k / 3 % 3), 2'(k % 3)};
      @(posedge sys_clk_in);
      e = int'(fresh || (l != lvl));
      base_c = n_c;
      lvl <= l;
      rst_pos <= p;
      repeat (8) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      check_bits("mode_outputs", model(k % 3, k / 3 % 3, k / 9 % 3, k / 27, p),
         {ext, alt, rhigh, diff, neg, rst, cal_long, dual, cs});
      check_cnt("mode_change", e, int'(n_c != base_c));
      fresh = 1'b0;
   endtask

   // Falls are counted on the q strobe, so this suits single-edge modes only
   task automatic run_cal(logic [7:0] l, int exp);
      @(posedge sys_clk_in) lvl <= l;
      do_reset();
      base_q = n_q;
      clk_run <= 1'b1;
      for (int t = 0; t < 400 && cal_start !== 1'b1; t++) @(negedge sys_clk_in);
      // A timeout counts as a mismatch; the run still ends in close_out
      if (cal_start !== 1'b1) begin
         check_cnt("cal_timeout", 1, 0);
      end else begin
         check_cnt("cal_falls", exp, n_q - base_q + int'(q_stb === 1'b1));
      end
      @(posedge sys_clk_in) clk_run <= 1'b0;
   endtask

   // Any window of whole clock periods holds one fall and one rise per period
   task automatic run_strobes(logic [7:0] l, int ei, int eq);
      @(posedge sys_clk_in) lvl <= l;
      repeat (10) @(posedge sys_clk_in);
      clk_run <= 1'b1;
      repeat (20) @(posedge sys_clk_in);
      base_i = n_i;
      base_q = n_q;
      repeat (120) @(posedge sys_clk_in);
      check_cnt("i_strobes", ei, n_i - base_i);
      check_cnt("q_strobes", eq, n_q - base_q);
      clk_run <= 1'b0;
   endtask

   initial begin
      void'($urandom(32'h4d65));
      do_reset();
      for (int k = 0; k < 81; k++) apply(k, 1'($urandom % 2));
      for (int n = 0; n < 40; n++) apply(int'($urandom % 81), 1'($urandom % 2));
      run_cal(8'h55, LONG);
      run_cal(8'h15, SHORT);
      run_cal(8'h45, SHORT);
      run_strobes(8'h95, 20, 0);
      run_strobes(8'h15, 10, 10);
      close_out();
   end
endmodule // strap_pin_mode_decoder_tb

bind strap_pin_mode_decoder strap_mode_props strap_mode_props_i (
   .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ext_en_cmp_hi_in(ext_en_cmp_hi_in),
   .ext_en_cmp_lo_in(ext_en_cmp_lo_in), .sample_clk_pos_in(sample_clk_pos_in),
   .ext_ctrl_mode_out(ext_ctrl_mode_out), .alt_ext_ctrl_enable_out(alt_ext_ctrl_enable_out),
   .range_select_high_out(range_select_high_out), .diff_reset_mode_out(diff_reset_mode_out),
   .cal_delay_long_out(cal_delay_long_out), .cal_start_out(cal_start_out),
   .cal_pending_out(cal_pending_out), .dual_edge_mode_out(dual_edge_mode_out),
   .i_sample_strobe_out(i_sample_strobe_out), .q_sample_strobe_out(q_sample_strobe_out),
   .serial_chip_select_out(serial_chip_select_out), .mode_change_out(mode_change_out));

`default_nettype wire
